// ==== pkg/pswc_pkg.sv ====
/*
  Package for the power state and wake controller: state encodings,
  switch timing, output carrier struct.
  Assumes a 50 MHz standby clock.
*/
package pswc_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned SHORT_PRESS_S = 4;
  localparam int unsigned FORCE_OFF_S = 6;
  localparam int unsigned SHORT_PRESS_CYC = CLK_HZ * SHORT_PRESS_S;
  localparam int unsigned FORCE_OFF_CYC = CLK_HZ * FORCE_OFF_S;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0]
  {
    PSWC_S0 = 3'h0,
    PSWC_S3 = 3'h1,
    PSWC_S4 = 3'h2,
    PSWC_S5 = 3'h3
  } pswc_state_t;

  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_MAIN = 2'h1;
  localparam logic [1:0] LED_SECOND = 2'h2;

  localparam logic [1:0] RESTORE_OFF = 2'h0;
  localparam logic [1:0] RESTORE_ON = 2'h1;
  localparam logic [1:0] RESTORE_LAST = 2'h2;

  typedef struct packed
  {
    logic main_power_en;
    logic standby_power_en;
    logic [1:0] led;
  } pswc_power_t;

  typedef struct packed
  {
    logic lan;
    logic usb;
    logic pcie;
    logic rtc;
    logic infrared_remote_wake;
    logic radio;
  } pswc_wake_t;

endpackage : pswc_pkg

// ==== rtl/pswc_switch_timer.sv ====
/*
  Power switch debounce and hold timer.
  Assumes a synchronous active-high switch level.
*/
`timescale 1ns/100ps
module pswc_switch_timer #(
  parameter int unsigned DEBOUNCE = pswc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_LIM = pswc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned FORCE_LIM = pswc_pkg::FORCE_OFF_CYC
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Raw switch
  input wire logic i_switch,
  // Events
  output logic o_short_press,
  output logic o_force_off
);

  logic pressed;
  logic forced;
  logic [pswc_pkg::CNT_W-1:0] db_cnt;
  logic [pswc_pkg::CNT_W-1:0] hold_cnt;
  wire db_done = db_cnt >= pswc_pkg::CNT_W'(DEBOUNCE);
  wire raw_diff = i_switch != pressed;
  wire hold_hit = pressed && !forced &&
    hold_cnt >= pswc_pkg::CNT_W'(FORCE_LIM - 1);
  wire release_short = raw_diff && db_done && pressed && !forced &&
    hold_cnt < pswc_pkg::CNT_W'(SHORT_LIM);

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pressed <= 1'b0;
      forced <= 1'b0;
      db_cnt <= '0;
      hold_cnt <= '0;
      o_short_press <= 1'b0;
      o_force_off <= 1'b0;
    end
    else
    begin
      db_cnt <= raw_diff ? db_cnt + 1'b1 : '0;
      if (raw_diff && db_done)
        pressed <= i_switch;
      // Hold counted from debounced press
      hold_cnt <= (pressed && !(raw_diff && db_done)) ? hold_cnt + 1'b1 : '0;
      if (!pressed)
        forced <= 1'b0;
      else if (hold_hit)
        forced <= 1'b1;
      // Fires while still held, no release needed
      o_force_off <= hold_hit;
      // Presses between four and six seconds do nothing
      o_short_press <= release_short;
    end
  end

endmodule : pswc_switch_timer

// ==== rtl/pswc_controller.sv ====
/*
  Power state and wake controller top: tracks S0/S3/S4/S5, switch
  actions, wake sources, supply enables and indicator LED.
  Assumes synchronous inputs and a 50 MHz standby clock.
*/
`timescale 1ns/100ps
module pswc_controller #(
  parameter int unsigned DEBOUNCE = pswc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_LIM = pswc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned FORCE_LIM = pswc_pkg::FORCE_OFF_CYC,
  parameter bit LED_DUAL = 1'b1
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Front switch
  input wire logic i_switch,
  // OS sleep requests and policy
  input wire logic i_sleep_to_s5,
  input wire logic i_os_sleep_req,
  input wire logic [2:0] i_os_sleep_state,
  // Mains and restore policy
  input wire logic i_mains_return,
  input wire logic [1:0] i_restore_policy,
  input wire logic i_last_on,
  // Wake sources and qualifiers
  input wire pswc_pkg::pswc_wake_t i_wake,
  input wire logic i_usb_s45_en,
  input wire logic i_rtc_alarm_set,
  input wire logic i_deep_sleep_variant,
  // Outputs
  output pswc_pkg::pswc_power_t o_power,
  output logic [2:0] o_state,
  output logic o_sleep_notify
);

  logic short_press;
  logic force_off;
  logic after_g3;
  logic restore_pend;
  pswc_pkg::pswc_state_t state;
  pswc_pkg::pswc_state_t next_state;

  pswc_switch_timer #(
    .DEBOUNCE(DEBOUNCE),
    .SHORT_LIM(SHORT_LIM),
    .FORCE_LIM(FORCE_LIM)
  ) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_switch(i_switch),
    .o_short_press(short_press),
    .o_force_off(force_off)
  );

  // S4 or S5, whatever the deep variant says
  function automatic logic is_s4_s5(input pswc_pkg::pswc_state_t s);
    is_s4_s5 = s == pswc_pkg::PSWC_S4 || s == pswc_pkg::PSWC_S5;
  endfunction : is_s4_s5

  wire in_s3 = state == pswc_pkg::PSWC_S3;
  wire in_s4 = state == pswc_pkg::PSWC_S4;
  wire in_s5 = state == pswc_pkg::PSWC_S5;
  wire far_asleep = is_s4_s5(state);

  // One gate bit per source, in wake-struct order
  localparam int unsigned N_WAKE = $bits(pswc_pkg::pswc_wake_t);
  logic [N_WAKE-1:0] wake_gate;
  logic [N_WAKE-1:0] wake_hit;

  assign wake_gate[5] = in_s3 || far_asleep;
  assign wake_gate[4] = !after_g3 &&
    (in_s3 || (far_asleep && i_usb_s45_en));
  assign wake_gate[3] = in_s3 || in_s4;
  assign wake_gate[2] = i_rtc_alarm_set && in_s5;
  assign wake_gate[1] = in_s3 ||
    (is_s4_s5(state) && !i_deep_sleep_variant);
  // Radio slot kept so indices match the struct
  assign wake_gate[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < N_WAKE; gi++)
    begin : g_wake
      assign wake_hit[gi] = i_wake[gi] && wake_gate[gi];
    end
  endgenerate

  wire any_wake = |wake_hit;
  wire restore_on = i_restore_policy == pswc_pkg::RESTORE_ON ||
    (i_restore_policy == pswc_pkg::RESTORE_LAST && i_last_on);
  wire os_to_sleep = i_os_sleep_req &&
    (i_os_sleep_state == pswc_pkg::PSWC_S3 ||
     i_os_sleep_state == pswc_pkg::PSWC_S4 ||
     i_os_sleep_state == pswc_pkg::PSWC_S5);

  always_comb
  begin
    next_state = state;
    case (state)
      pswc_pkg::PSWC_S0:
      begin
        if (force_off)
          next_state = pswc_pkg::PSWC_S5;
        else if (os_to_sleep)
          next_state = pswc_pkg::pswc_state_t'(i_os_sleep_state);
      end
      pswc_pkg::PSWC_S3, pswc_pkg::PSWC_S4:
      begin
        if (force_off)
          next_state = pswc_pkg::PSWC_S5;
        else if (short_press || any_wake)
          next_state = pswc_pkg::PSWC_S0;
      end
      pswc_pkg::PSWC_S5:
      begin
        if (restore_pend)
          next_state = restore_on ? pswc_pkg::PSWC_S0 : pswc_pkg::PSWC_S5;
        else if (short_press || any_wake)
          next_state = pswc_pkg::PSWC_S0;
      end
      default:
        next_state = pswc_pkg::PSWC_S5;
    endcase
  end

  wire next_main = next_state == pswc_pkg::PSWC_S0;
  wire [1:0] next_led = next_main ? pswc_pkg::LED_MAIN :
    (next_state == pswc_pkg::PSWC_S3 && LED_DUAL) ?
    pswc_pkg::LED_SECOND : pswc_pkg::LED_OFF;

  // State and its port copy load together
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state <= pswc_pkg::PSWC_S5;
      o_state <= pswc_pkg::PSWC_S5;
    end
    else
    begin
      state <= next_state;
      o_state <= next_state;
    end
  end

  // Mains flags; a mains return beats a boot in the same cycle
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      after_g3 <= 1'b1;
      restore_pend <= 1'b1;
    end
    else
    begin
      restore_pend <= i_mains_return;
      // Cleared by a boot, set again by mains return
      if (i_mains_return)
        after_g3 <= 1'b1;
      else if (next_main)
        after_g3 <= 1'b0;
    end
  end

  // Supply, LED and notify outputs
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_power <= '{1'b0, 1'b1, pswc_pkg::LED_OFF};
      o_sleep_notify <= 1'b0;
    end
    else
    begin
      o_power <= '{next_main, 1'b1, next_led};
      // Switch press in S0 hands the choice to the OS
      o_sleep_notify <= in_s0_press(state, short_press);
    end
  end

  function automatic logic in_s0_press(input pswc_pkg::pswc_state_t s,
                                       input logic p);
    in_s0_press = (s == pswc_pkg::PSWC_S0) && p;
  endfunction : in_s0_press

endmodule : pswc_controller

// ==== tb/pswc_properties.sv ====
/*
  Checker on the controller top ports.
  Assumes the bind below and shortened switch counts.
*/
`timescale 1ns/100ps
module pswc_properties #(
  parameter int unsigned DEBOUNCE = 4,
  parameter int unsigned FORCE_LIM = 60
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Inputs
  input wire logic i_switch,
  input wire logic i_mains_return,
  input wire pswc_pkg::pswc_wake_t i_wake,
  input wire logic i_usb_s45_en,
  input wire logic i_deep_sleep_variant,
  // Outputs
  input wire pswc_pkg::pswc_power_t o_power,
  input wire logic [2:0] o_state,
  input wire logic o_sleep_notify
);
  logic [31:0] held;
  wire calm = !i_switch && !i_mains_return;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Raw hold length; slack of 4 covers debounce skew
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      held <= 32'h0;
    else
      held <= i_switch ? held + 32'h1 : 32'h0;
  end
  // Restore policy owns the cycle after reset or mains return
  sequence s_asleep;
    o_state != 3'h0 && calm && !$past(i_reset) && !$past(i_mains_return);
  endsequence
  a_s0_main_on: assert property (o_state == 3'h0 |-> o_power[3])
    else $error("main off in S0");
  a_notify_pulse: assert property (o_sleep_notify |=> !o_sleep_notify)
    else $error("notify too long");
  a_s3_standby: assert property (o_state == 3'h1 |->
    o_power[3:2] == 2'h1 && !o_power[0])
    else $error("bad S3 supply");
  a_lan_wake: assert property (s_asleep ##0 i_wake.lan |=>
    o_state == 3'h0)
    else $error("lan wake missed");
  a_usb_gate: assert property (s_asleep ##0 o_state > 3'h1 &&
    i_wake == 6'h10 && !i_usb_s45_en |=> $stable(o_state))
    else $error("usb wake not gated");
  a_pcie_s5: assert property (s_asleep ##0 o_state == 3'h3 &&
    i_wake == 6'h08 |=> o_state == 3'h3)
    else $error("pcie woke S5");
  a_ir_deep: assert property (s_asleep ##0 o_state > 3'h1 &&
    i_deep_sleep_variant && i_wake == 6'h02 |=> $stable(o_state))
    else $error("ir woke deep sleep");
  a_radio_none: assert property (s_asleep ##0 i_wake == 6'h01 |=>
    $stable(o_state))
    else $error("radio woke system");
  a_force_off: assert property (held == DEBOUNCE + FORCE_LIM + 4 |->
    o_state == 3'h3)
    else $error("force off missed");
endmodule : pswc_properties
bind pswc_controller pswc_properties #(.DEBOUNCE(DEBOUNCE),
  .FORCE_LIM(FORCE_LIM)) props_u (.*);

// ==== tb/pswc_partner.sv ====
/*
  Front switch model: holds the switch a commanded count.
  Assumes one go pulse per press.
*/
`timescale 1ns/100ps
module pswc_partner (
  // Clock
  input wire logic i_clk,
  // Press command
  input wire logic i_go,
  input wire logic [7:0] i_hold,
  // Switch level
  output logic o_switch
);
  logic [7:0] left = 8'h00;
  always_ff @(posedge i_clk)
  begin
    if (i_go)
      left <= i_hold;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  // Clean contact; bounce left out
  assign o_switch = left != 8'h00;
endmodule : pswc_partner

// ==== tb/tb_pswc_controller.sv ====
/*
  Bench for the power state and wake controller.
  Assumes the partner model drives the switch.
*/
`timescale 1ns/100ps
module tb_pswc_controller;
  logic clk = 0, rst = 1, go = 0, req = 0, mains = 0, en = 0, deep = 0;
  logic last = 1, rtc_set = 1;
  logic sw, notify;
  logic [7:0] hold = 8'h00;
  logic [2:0] st, sl = 3'h0;
  logic [1:0] pol = 2'h0;
  pswc_pkg::pswc_power_t pwr;
  pswc_pkg::pswc_wake_t wake = 6'h00;
  logic [13:0] rows [11];
  int fail_count = 0, n_checks = 0, cyc = 0, k;
  pswc_partner partner_u (.i_clk(clk), .i_go(go), .i_hold(hold),
    .o_switch(sw));
  pswc_controller #(.DEBOUNCE(4), .SHORT_LIM(40), .FORCE_LIM(60)) dut_u (
    .i_clk(clk), .i_reset(rst), .i_switch(sw), .i_sleep_to_s5(1'b0),
    .i_os_sleep_req(req), .i_os_sleep_state(sl), .i_mains_return(mains),
    .i_restore_policy(pol), .i_last_on(last), .i_wake(wake),
    .i_usb_s45_en(en), .i_rtc_alarm_set(rtc_set),
    .i_deep_sleep_variant(deep), .o_power(pwr), .o_state(st),
    .o_sleep_notify(notify));
  initial forever #10 clk = ~clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic poke(logic [5:0] w);
    @(posedge clk) wake <= w;
    @(posedge clk) wake <= 6'h00;
    @(negedge clk);
  endtask : poke
  task automatic go_to(logic [2:0] s);
    // Lan reaches S0 from every sleep state
    if (st !== 3'h0)
      poke(6'h20);
    @(posedge clk) {req, sl} <= {s != 3'h0, s};
    @(posedge clk) req <= 1'b0;
    @(negedge clk);
  endtask : go_to
  task automatic press(logic [7:0] h, int w);
    @(posedge clk) {go, hold} <= {1'b1, h};
    @(posedge clk) go <= 1'b0;
    repeat (w) @(negedge clk);
  endtask : press
  task automatic restore(logic [1:0] p, logic l);
    @(posedge clk) {rst, mains, pol, last} <= {1'b1, 1'b1, p, l};
    @(posedge clk) rst <= 1'b0;
    @(posedge clk) mains <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : restore
  initial
  begin
    // From state, wake, deep and usb enable, expected state
    rows[0] = {3'h1, 6'h20, 2'h0, 3'h0};
    rows[1] = {3'h3, 6'h20, 2'h0, 3'h0};
    rows[2] = {3'h1, 6'h10, 2'h0, 3'h0};
    rows[3] = {3'h2, 6'h10, 2'h0, 3'h2};
    rows[4] = {3'h3, 6'h10, 2'h1, 3'h0};
    rows[5] = {3'h2, 6'h08, 2'h0, 3'h0};
    rows[6] = {3'h3, 6'h08, 2'h0, 3'h3};
    rows[7] = {3'h3, 6'h04, 2'h0, 3'h0};
    rows[8] = {3'h2, 6'h02, 2'h0, 3'h0};
    rows[9] = {3'h3, 6'h02, 2'h2, 3'h3};
    rows[10] = {3'h1, 6'h01, 2'h0, 3'h1};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) en <= 1'b1;
    poke(6'h10);
    chk("reset state", 4'h3, {1'b0, st});
    chk("reset power", 4'h4, pwr);
    $display("test reset done");
    for (k = 0; k < 11; k++)
    begin
      go_to(rows[k][13:11]);
      @(posedge clk) {deep, en} <= rows[k][4:3];
      poke(rows[k][10:5]);
      chk("wake", {1'b0, rows[k][2:0]}, {1'b0, st});
      $display("test row %0d done", k);
    end
    go_to(3'h1);
    chk("sleep power", 4'h6, pwr);
    press(8'h0a, 30);
    chk("press wake", 4'h0, {1'b0, st});
    chk("run power", 4'hd, pwr);
    press(8'h0a, 0);
    k = 0;
    repeat (30)
    begin
      @(negedge clk);
      k += notify;
    end
    chk("notify", 4'h1, k[3:0]);
    press(8'hc8, 75);
    chk("forced off", 4'h3, {1'b0, st});
    repeat (140) @(negedge clk);
    press(8'h0a, 30);
    chk("off press", 4'h0, {1'b0, st});
    $display("test switch done");
    restore(2'h2, 1'b1);
    chk("restore last on", 4'h0, {1'b0, st});
    restore(2'h2, 1'b0);
    chk("restore last off", 4'h3, {1'b0, st});
    @(posedge clk) rtc_set <= 1'b0;
    poke(6'h04);
    chk("rtc unset", 4'h3, {1'b0, st});
    restore(2'h1, 1'b0);
    chk("restore on", 4'h0, {1'b0, st});
    $display("test restore done");
    close_out();
  end
endmodule : tb_pswc_controller
